// [rtl/sdram_core.sv]
/*
 command decode, bank state, burst counter and clock suspend logic.
 assumes: one clock, inputs synchronous to clk; the controller keeps
 to bank-state and burst-state legality.
*/
`timescale 1ns/100ps
`default_nettype none
module sdram_core
   import sdram_cmd_pkg::*;
#(
   parameter logic [BURST_W-1:0] BURST_LEN = BURST_LEN_DEF
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   // command pins
   input  wire logic              chip_select_n,
   input  wire logic              row_strobe_n,
   input  wire logic              col_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic              clock_enable,
   input  wire logic              bank_select,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [LANES-1:0]  data_mask,
   // state out
   output logic [BANKS-1:0]       bank_active_r,
   output logic                   burst_busy_r,
   output logic                   burst_write_r,
   output logic                   auto_pre_r,
   output logic [BURST_W-1:0]     burst_step_r,
   output logic                   suspended_r,
   output logic                   power_down_r,
   output logic                   self_refresh_r,
   output logic [LANES-1:0]       write_lane_en_r,
   output logic [LANES-1:0]       read_drive_en_r,
   output logic                   mode_set_r,
   output logic                   refresh_r
);
   logic  cke_prev_r;
   pwr_t  pwr_r;
   cmd_t  cmd;
   logic  run;

   // previous clock enable level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         cke_prev_r <= 1'b1;
      else if (clk_en)
         cke_prev_r <= clock_enable;
   end

   sdram_cmd_decode u_dec (
      .chip_select_n  (chip_select_n),
      .row_strobe_n   (row_strobe_n),
      .col_strobe_n   (col_strobe_n),
      .write_strobe_n (write_strobe_n),
      .cke_prev       (cke_prev_r),
      .cke_cur        (clock_enable),
      .cmd            (cmd)
   );

   // commands take effect only while running
   assign run = clk_en && (pwr_r == ST_RUN) && cke_prev_r;

   // power state: suspend, power-down, self refresh
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         pwr_r <= ST_RUN;
      else if (clk_en) begin
         case (pwr_r)
            ST_RUN:
               if (cke_prev_r && !clock_enable) begin
                  if (cmd == CMD_SREF)
                     pwr_r <= ST_SREF;
                  else if (burst_busy_r || (|bank_active_r))
                     pwr_r <= ST_SUSPEND;
                  else
                     pwr_r <= ST_PDOWN;
               end
            ST_SUSPEND, ST_PDOWN, ST_SREF:
               if (clock_enable)
                  pwr_r <= ST_RUN;
            default: pwr_r <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         suspended_r    <= 1'b0;
         power_down_r   <= 1'b0;
         self_refresh_r <= 1'b0;
      end else if (clk_en) begin
         suspended_r    <= (pwr_r == ST_SUSPEND);
         power_down_r   <= (pwr_r == ST_PDOWN);
         self_refresh_r <= (pwr_r == ST_SREF);
      end
   end

   // bank open/close
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         bank_active_r <= '0;
      else if (run) begin
         if (cmd == CMD_ACT)
            bank_active_r[bank_select] <= 1'b1;
         else if (cmd == CMD_PRE) begin
            if (addr[AP_BIT])
               bank_active_r <= '0;
            else
               bank_active_r[bank_select] <= 1'b0;
         end else if (burst_busy_r && auto_pre_r && !(|burst_step_r))
            bank_active_r <= '0;
      end
   end

   // burst counter; frozen when not running, nop keeps it going
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         burst_busy_r  <= 1'b0;
         burst_write_r <= 1'b0;
         auto_pre_r    <= 1'b0;
         burst_step_r  <= '0;
      end else if (run) begin
         if (cmd == CMD_RD || cmd == CMD_WR) begin
            burst_busy_r  <= 1'b1;
            burst_write_r <= (cmd == CMD_WR);
            auto_pre_r    <= addr[AP_BIT];
            burst_step_r  <= BURST_LEN - 4'h1;
         end else if (cmd == CMD_BST || cmd == CMD_PRE) begin
            burst_busy_r <= 1'b0;
            burst_step_r <= '0;
         end else if (burst_busy_r) begin
            if (burst_step_r == '0)
               burst_busy_r <= 1'b0;
            else
               burst_step_r <= burst_step_r - 4'h1;
         end
      end
   end

   // byte lane gating
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         write_lane_en_r <= '0;
         read_drive_en_r <= '0;
      end else if (clk_en) begin
         write_lane_en_r <= (run && (|bank_active_r)) ? ~data_mask : '0;
         read_drive_en_r <= (run && (|bank_active_r)) ? ~data_mask : '0;
      end
   end

   // one-cycle command pulses
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_set_r <= 1'b0;
         refresh_r  <= 1'b0;
      end else if (clk_en) begin
         mode_set_r <= run && (cmd == CMD_MRS);
         refresh_r  <= run && (cmd == CMD_REF);
      end
   end

   sequence s_low_active;
      pwr_r == ST_RUN && cke_prev_r && !clock_enable && |bank_active_r
         && cmd != CMD_SREF;
   endsequence
   property p_suspend_entry;
      @(posedge clk) disable iff (!resetn)
      clk_en throughout s_low_active ##1 clk_en |=> suspended_r;
   endproperty
   a_suspend_entry: assert property (p_suspend_entry)
      else $error("no suspend after cke low with bank active");

   property p_no_pdown_burst;
      @(posedge clk) disable iff (!resetn)
      (clk_en && burst_busy_r && pwr_r == ST_RUN && cke_prev_r
         && !clock_enable) |=> pwr_r != ST_PDOWN;
   endproperty
   a_no_pdown_burst: assert property (p_no_pdown_burst)
      else $error("power-down entered during burst");

   property p_freeze;
      @(posedge clk) disable iff (!resetn)
      (pwr_r == ST_SUSPEND) |=> $stable(burst_step_r);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("burst moved in suspend");

   property p_ignore;
      @(posedge clk) disable iff (!resetn)
      (pwr_r == ST_SUSPEND) |=> $stable(bank_active_r);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("command taken in suspend");

   property p_exit;
      @(posedge clk) disable iff (!resetn)
      (clk_en && pwr_r == ST_SUSPEND && clock_enable) |=> pwr_r == ST_RUN;
   endproperty
   a_exit: assert property (p_exit)
      else $error("suspend not left");

   property p_act;
      @(posedge clk) disable iff (!resetn)
      (run && cmd == CMD_ACT) |=> bank_active_r[$past(bank_select)];
   endproperty
   a_act: assert property (p_act)
      else $error("activate ignored");

   property p_mask;
      @(posedge clk) disable iff (!resetn)
      (clk_en && run && |bank_active_r) |=> read_drive_en_r ==
         ~$past(data_mask);
   endproperty
   a_mask: assert property (p_mask)
      else $error("mask gating wrong");

   property p_deselect;
      @(posedge clk) disable iff (!resetn)
      chip_select_n |-> cmd == CMD_DESEL;
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("deselect decoded as command");
endmodule
`default_nettype wire

// [rtl/sdram_cmd_pkg.sv]
/*
 command decode and clock suspend constants for a two-bank 16-bit
 synchronous dram front end.
 assumes: included before the decode modules.
*/
package sdram_cmd_pkg;
   localparam int BANKS      = 2;
   localparam int ADDR_W     = 11;
   localparam int LANES      = 2;
   localparam int AP_BIT     = 10;   // precharge_select_addr_bit position
   localparam int BURST_W    = 4;
   localparam logic [BURST_W-1:0] BURST_LEN_DEF = 4'h4;
   // strobe codes {row, col, write}
   localparam logic [2:0] CODE_MRS = 3'h0;
   localparam logic [2:0] CODE_REF = 3'h1;
   localparam logic [2:0] CODE_PRE = 3'h2;
   localparam logic [2:0] CODE_ACT = 3'h3;
   localparam logic [2:0] CODE_WR  = 3'h4;
   localparam logic [2:0] CODE_RD  = 3'h5;
   localparam logic [2:0] CODE_BST = 3'h6;
   localparam logic [2:0] CODE_NOP = 3'h7;

   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
      CMD_MRS, CMD_REF, CMD_SREF, CMD_BST
   } cmd_t;

   typedef enum logic [1:0] {
      ST_RUN, ST_SUSPEND, ST_PDOWN, ST_SREF
   } pwr_t;
endpackage

// [rtl/sdram_cmd_decode.sv]
/*
 combinational command decoder from chip select and strobes.
 assumes: output sampled on the clock edge by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module sdram_cmd_decode
   import sdram_cmd_pkg::*;
(
   // strobes
   input  wire logic chip_select_n,
   input  wire logic row_strobe_n,
   input  wire logic col_strobe_n,
   input  wire logic write_strobe_n,
   // clock enable pair
   input  wire logic cke_prev,
   input  wire logic cke_cur,
   // result
   output cmd_t      cmd
);
   always_comb begin
      cmd = CMD_DESEL;
      if (!chip_select_n && cke_prev) begin
         case ({row_strobe_n, col_strobe_n, write_strobe_n})
            CODE_ACT: cmd = CMD_ACT;
            CODE_RD:  cmd = CMD_RD;
            CODE_WR:  cmd = CMD_WR;
            CODE_PRE: cmd = CMD_PRE;
            CODE_MRS: cmd = CMD_MRS;
            CODE_REF: cmd = cke_cur ? CMD_REF : CMD_SREF;
            CODE_BST: cmd = CMD_BST;
            default:  cmd = CMD_NOP;
         endcase
      end
   end
endmodule
`default_nettype wire

// [test/ctrl_model.sv]
/*
 memory controller model driving the command pins of sdram_core.
 assumes: called from the bench; pins change just after a rising clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ctrl_model
   import sdram_cmd_pkg::*;
(
   // clock
   input  wire logic         clk,
   // command pins
   output logic              cs_n,
   output logic              ras_n,
   output logic              cas_n,
   output logic              we_n,
   output logic              cke,
   output logic              ba,
   output logic [ADDR_W-1:0] a
);
   initial begin
      {cs_n, ras_n, cas_n, we_n, cke, ba} = 6'h3f;
      a = '0;
   end
   // bank legality kept by caller order; burst stop never sent
   // cke stays as given, exit from low power under nop or deselect
   task automatic issue(input logic c, input logic [2:0] code,
                        input logic b, input logic p, input logic k);
      @(posedge clk);
      cs_n <= c;
      {ras_n, cas_n, we_n} <= code;
      ba <= b;
      a <= ADDR_W'(p) << AP_BIT;
      cke <= k;
      @(posedge clk);
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= CODE_NOP;
      a <= ~a;
      ba <= ~ba;
   endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
/*
 self-checking bench for sdram_core.
 assumes: sdram_cmd_pkg compiled first; default burst length.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
   import sdram_cmd_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [LANES-1:0] dm = '0;
   logic cs_n, ras_n, cas_n, we_n, cke, ba;
   logic [ADDR_W-1:0] a;
   logic [BANKS-1:0] act;
   logic busy, wr, ap, sus, pd, sr, ms, rf;
   logic [BURST_W-1:0] step;
   logic [LANES-1:0] wle, rde;
   int err_total = 0;
   int tests_run = 0;
   int n;
   logic [BURST_W-1:0] s;

   always #2 clk = ~clk;

   ctrl_model ctl(.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .cke(cke), .ba(ba), .a(a));
   sdram_core dut(.clk(clk), .resetn(resetn), .clk_en(1'b1),
      .chip_select_n(cs_n), .row_strobe_n(ras_n), .col_strobe_n(cas_n),
      .write_strobe_n(we_n), .clock_enable(cke), .bank_select(ba),
      .addr(a), .data_mask(dm), .bank_active_r(act),
      .burst_busy_r(busy), .burst_write_r(wr), .auto_pre_r(ap),
      .burst_step_r(step), .suspended_r(sus), .power_down_r(pd),
      .self_refresh_r(sr), .write_lane_en_r(wle),
      .read_drive_en_r(rde), .mode_set_r(ms), .refresh_r(rf));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task cmd(input logic c, input logic [2:0] code, input logic b,
            input logic p);
      ctl.issue(c, code, b, p, 1'b1);
      tick(1);
   endtask
   // beats while busy, bounded
   task burst;
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         n++;
         tick(1);
      end
      if (n == 20) begin
         err_total++;
         conclude;
      end
   endtask

   task t_decode;
      chk(act, 16'h0);
      cmd(0, CODE_ACT, 0, 0);
      chk(act, 16'h1);
      cmd(0, CODE_ACT, 1, 0);
      chk(act, 16'h3);
      cmd(1, CODE_PRE, 0, 1);
      chk(act, 16'h3);
      cmd(0, CODE_PRE, 0, 0);
      chk(act, 16'h2);
      cmd(0, CODE_PRE, 0, 1);
      chk(act, 16'h0);
      ctl.issue(0, CODE_MRS, 0, 0, 1);
      tick(0);
      chk(ms, 16'h1);
      ctl.issue(0, CODE_REF, 0, 0, 1);
      tick(0);
      chk({ms, rf}, 16'h1);
      tick(1);
      chk(rf, 16'h0);
      $display("done decode");
   endtask
   task t_burst;
      cmd(0, CODE_ACT, 0, 0);
      ctl.issue(0, CODE_RD, 0, 0, 1);
      tick(0);
      chk(step, BURST_LEN_DEF - 4'h1);
      burst;
      chk(16'(n), BURST_LEN_DEF);
      ctl.issue(0, CODE_WR, 0, 1, 1);
      tick(1);
      chk({wr, ap}, 16'h3);
      burst;
      chk(act, 16'h0);
      $display("done burst");
   endtask
   task t_suspend;
      cmd(0, CODE_ACT, 0, 0);
      ctl.issue(0, CODE_RD, 0, 0, 1);
      tick(0);
      ctl.issue(0, CODE_NOP, 0, 0, 0);
      tick(0);
      chk(step, BURST_LEN_DEF - 4'h3);
      tick(2);
      ctl.issue(0, CODE_PRE, 0, 1, 0);
      tick(2);
      s = step;
      tick(3);
      chk(step, s);
      chk({sus, pd}, 16'h2);
      chk(busy, 16'h1);
      chk(act, 16'h1);
      ctl.issue(0, CODE_NOP, 0, 0, 1);
      tick(2);
      chk(sus, 16'h0);
      burst;
      chk(act, 16'h1);
      cmd(0, CODE_PRE, 0, 1);
      $display("done suspend");
   endtask
   task t_mask;
      cmd(0, CODE_ACT, 0, 0);
      @(posedge clk) dm <= 2'h1;
      tick(2);
      chk({wle, rde}, 16'ha);
      cmd(0, CODE_PRE, 0, 1);
      tick(1);
      chk({wle, rde}, 16'h0);
      @(posedge clk) dm <= 2'h0;
      $display("done mask");
   endtask
   task t_power;
      ctl.issue(0, CODE_NOP, 0, 0, 0);
      tick(3);
      chk({pd, sus}, 16'h2);
      ctl.issue(0, CODE_NOP, 0, 0, 1);
      tick(3);
      chk(pd, 16'h0);
      ctl.issue(0, CODE_REF, 0, 0, 0);
      tick(3);
      chk({sr, rf}, 16'h2);
      ctl.issue(1, CODE_NOP, 0, 0, 1);
      tick(3);
      chk(sr, 16'h0);
      cmd(0, CODE_ACT, 1, 0);
      chk(act, 16'h2);
      $display("done power");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      tick(1);
      t_decode;
      t_burst;
      t_suspend;
      t_mask;
      t_power;
      conclude;
   end
endmodule
`default_nettype wire
